//--- inc/dsc_pkg.sv
// Constants, register map and state type for the upper-stream DMA config block.
package dsc_pkg;

	// -------------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------------
	localparam logic [11:0] UPPER_STATUS_OFS = 12'h004;
	localparam logic [11:0] UPPER_CLEAR_OFS  = 12'h00C;
	localparam logic [11:0] CFG_BASE_OFS     = 12'h010;
	localparam logic [11:0] MODE_BASE_OFS    = 12'h024;
	localparam logic [11:0] STREAM_STRIDE    = 12'h018;
	localparam int          FIRST_STREAM     = 4;
	localparam int          NUM_STREAMS      = 4;

	localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
	localparam logic [31:0] CFG_RW_MASK      = 32'h0FEF_FFFF;
	localparam logic [31:0] CFG_LIVE_MASK    = 32'h0000_001F;
	localparam logic [1:0]  MODE_RESET       = 2'h0;

	// -------------------------------------------------------------------
	// Configuration field positions
	// -------------------------------------------------------------------
	localparam int REQ_LINE_LSB   = 25;
	localparam int MEM_BURST_LSB  = 23;
	localparam int PER_BURST_LSB  = 21;
	localparam int TARGET_BIT     = 19;
	localparam int DBUF_BIT       = 18;
	localparam int PRIO_LSB       = 16;
	localparam int FIXED4_BIT     = 15;
	localparam int MEM_WIDTH_LSB  = 13;
	localparam int PER_WIDTH_LSB  = 11;
	localparam int MEM_STEP_BIT   = 10;
	localparam int PER_STEP_BIT   = 9;
	localparam int WRAP_BIT       = 8;
	localparam int DIR_LSB        = 6;
	localparam int PACE_BIT       = 5;
	localparam int DONE_IE_BIT    = 4;
	localparam int HALF_IE_BIT    = 3;
	localparam int ERR_IE_BIT     = 2;
	localparam int DME_IE_BIT     = 1;
	localparam int EN_BIT         = 0;

	localparam int DMOFF_BIT      = 2;
	localparam int FIFO_IE_BIT    = 7;

	localparam logic [1:0] DIR_MEM2MEM = 2'h2;
	localparam logic [1:0] BURST_SINGLE = 2'h0;

	// -------------------------------------------------------------------
	// Flag layout inside the status and clear words
	// -------------------------------------------------------------------
	localparam int FLAG_FIFO   = 0;
	localparam int FLAG_DME    = 2;
	localparam int FLAG_ERR    = 3;
	localparam int FLAG_HALF   = 4;
	localparam int FLAG_DONE   = 5;
	localparam logic [31:0] FLAG_MASK = 32'h0F7D_0F7D;

	// -------------------------------------------------------------------
	// Whole block state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_STREAMS-1:0][31:0] cfg;
		logic [NUM_STREAMS-1:0][1:0]  mode;
		logic [31:0]                  flags;
		logic [31:0]                  prdata;
		logic                         pready;
		logic                         pslverr;
		logic [NUM_STREAMS-1:0]       irq;
	} dsc_state_t;

endpackage

//--- hdl/dsc_stream_ctrl.sv
// APB register block: stream configuration and upper-stream flag clearing.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Writing one to clear_complete bits 27,21,11,5 clears that stream's complete_flag.
// R2: Writing one to clear_half bits 26,20,10,4 clears that half_flag.
// R3: Writing one to clear_error bits 25,19,9,3 clears that error_flag.
// R4: Writing one to bits 24,18,8,2 clears directmode_error_flag.
// R5: Bits 22,16,6,0 clear fifo_error_flag; reserved clear bits do nothing.
// R6: request_line_select bits 27:25 choose request channel 0 to 7.
// R7: Protected fields accept writes only while stream_on is 0.
// R8: mem_beats_per_burst 24:23 selects single, INCR4, INCR8 or INCR16.
// R9: Direct mode forces mem_beats_per_burst to zero once enabled.
// R10: periph_beats_per_burst 22:21 same encoding, forced zero in direct mode.
// R11: current_target bit 19 set by software when off, toggled by hardware.
// R12: double_buffer_mode bit 18 switches memory target at each transfer end.
// R13: priority_level 17:16 ranks low, medium, high, very high.
// R14: periph_step_fixed_four bit 15 selects fixed four-byte peripheral step.
// R15: Enabled stream forces periph_step_fixed_four low in direct or burst mode.
// R16: Item widths 14:13 and 12:11 encode byte, half-word, word.
// R17: Direct mode copies periph_item_width into mem_item_width when enabled.
// R18: Address step bits 10 and 9 advance pointers by item width.
// R19: Enabled stream clears wraparound when peripheral paces, sets it for double buffer.
// R20: transfer_way 7:6 selects periph-to-mem, mem-to-periph, mem-to-mem.
// R21: periph_paces_transfer bit 5 forced zero for memory-to-memory.
// R22: Complete, half and error irq enables let events raise the interrupt.
// R23: directmode_error_irq_on bit 1 enables the direct mode error interrupt.
// R24: stream_on cleared at transfer end unless double_buffer_mode or wraparound is set, and at bus error or threshold mismatch.
// R25: Direct mode active when directmode_off is 0; forced 1 for mem-to-mem.
// R26: Stream interrupt follows enabled flags and drops when flags clear.

module dsc_stream_ctrl
	import dsc_pkg::*;
(
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Events from the transfer engine, one bit per upper stream
	input  wire logic [NUM_STREAMS-1:0]       evtComplete,
	input  wire logic [NUM_STREAMS-1:0]       evtHalf,
	input  wire logic [NUM_STREAMS-1:0]       evtError,
	input  wire logic [NUM_STREAMS-1:0]       evtDirectErr,
	input  wire logic [NUM_STREAMS-1:0]       evtFifoErr,
	input  wire logic [NUM_STREAMS-1:0]       xferEnd,
	input  wire logic [NUM_STREAMS-1:0]       busFault,
	input  wire logic [NUM_STREAMS-1:0]       thresholdBad,
	// Effective configuration towards the transfer engine, and per-stream interrupt requests
	output logic      [NUM_STREAMS-1:0][31:0] streamCfg,
	output logic      [NUM_STREAMS-1:0]       directModeOff,
	output logic      [NUM_STREAMS-1:0]       streamIrq
);

	// -------------------------------------------------------------------
	// Helper functions
	// -------------------------------------------------------------------

	// Byte address of a per-stream register for upper stream idx.
	function automatic logic [11:0] streamAddr(
		input logic [11:0] base,
		input int          idx
	);
		logic [11:0] num;
		num = 12'(FIRST_STREAM + idx);
		return 12'(base + 12'(STREAM_STRIDE * num));
	endfunction

	// Lowest bit of an upper stream's six-bit group in the flag words.
	function automatic int flagBase(input int idx);
		int pos;
		pos = 0;
		case (idx)
			0: pos = 0;
			1: pos = 6;
			2: pos = 16;
			3: pos = 22;
			default: pos = 0;
		endcase
		return pos;
	endfunction

	// Interrupt request of one stream from its flag group and enables.
	function automatic logic flagIrq(
		input logic [5:0]  flg,
		input logic [31:0] cw,
		input logic        fifoIe
	);
		logic req;
		req = 1'b0;
		req = req | (flg[FLAG_DONE] & cw[DONE_IE_BIT]);
		req = req | (flg[FLAG_HALF] & cw[HALF_IE_BIT]);
		req = req | (flg[FLAG_ERR]  & cw[ERR_IE_BIT]);
		req = req | (flg[FLAG_DME]  & cw[DME_IE_BIT]);
		req = req | (flg[FLAG_FIFO] & fifoIe);
		return req;
	endfunction

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	dsc_state_t s_q;
	dsc_state_t s_d;

	logic        accessCyc;
	logic        commit;
	logic        wrCommit;
	logic        rdPhase;
	logic        hit;
	logic [31:0] rdata;
	logic [31:0] clrBits;
	logic [31:0] setBits;
	logic [31:0] cfg;
	logic [1:0]  mode;
	logic        wasOn;
	logic        dmOff;
	logic [5:0]  fl;
	int          fb;

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb begin
		s_d       = s_q;
		accessCyc = psel & penable;
		commit    = accessCyc & s_q.pready;
		wrCommit  = commit & pwrite;
		rdPhase   = accessCyc & ~s_q.pready;
		hit       = 1'b0;
		rdata     = 32'h0000_0000;
		clrBits   = 32'h0000_0000;
		setBits   = 32'h0000_0000;
		cfg       = 32'h0000_0000;
		mode      = 2'h0;
		wasOn     = 1'b0;
		dmOff     = 1'b0;
		fl        = 6'h00;
		fb        = 0;

		// Address decode and read data for the access phase.
		if (paddr == UPPER_STATUS_OFS) begin
			hit   = 1'b1;
			rdata = s_q.flags;
		end
		if (paddr == UPPER_CLEAR_OFS) begin
			hit = 1'b1;
		end
		for (int i = 0; i < NUM_STREAMS; i++) begin
			if (paddr == streamAddr(CFG_BASE_OFS, i)) begin
				hit   = 1'b1;
				rdata = s_q.cfg[i];
			end
			if (paddr == streamAddr(MODE_BASE_OFS, i)) begin
				hit                = 1'b1;
				rdata              = 32'h0000_0000;
				rdata[DMOFF_BIT]   = s_q.mode[i][0];
				rdata[FIFO_IE_BIT] = s_q.mode[i][1];
			end
		end

		// The answer comes one cycle into the access phase.
		s_d.pready  = rdPhase;
		s_d.pslverr = rdPhase & ~hit;
		s_d.prdata  = (rdPhase & ~pwrite) ? rdata : 32'h0000_0000;

		// R1 R2 R3: clear strobes
		// R4 R5: clear strobes, reserved bits masked
		if (wrCommit && paddr == UPPER_CLEAR_OFS) begin
			clrBits = pwdata & FLAG_MASK;
		end

		for (int i = 0; i < NUM_STREAMS; i++) begin
			cfg   = s_q.cfg[i];
			mode  = s_q.mode[i];
			wasOn = cfg[EN_BIT];

			// R7: protected field writes
			// R6 R8 R13 R16 R18 R20: fields stored as written
			if (wrCommit && paddr == streamAddr(CFG_BASE_OFS, i)) begin
				if (wasOn) begin
					cfg = (cfg & ~CFG_LIVE_MASK) |
						(pwdata & CFG_LIVE_MASK);
				end else begin
					cfg = pwdata & CFG_RW_MASK;
				end
			end
			// R7: directmode_off locked while on
			if (wrCommit && !wasOn &&
				paddr == streamAddr(MODE_BASE_OFS, i)) begin
				mode[0] = pwdata[DMOFF_BIT];
				mode[1] = pwdata[FIFO_IE_BIT];
			end

			// R11 R12: target toggle at end
			// R24: stream stops at end
			if (wasOn && xferEnd[i]) begin
				if (cfg[DBUF_BIT]) begin
					cfg[TARGET_BIT] = ~cfg[TARGET_BIT];
				end else if (!cfg[WRAP_BIT]) begin
					cfg[EN_BIT] = 1'b0;
				end
			end
			// R24: error stops stream
			if (wasOn && (busFault[i] || thresholdBad[i])) begin
				cfg[EN_BIT] = 1'b0;
			end

			// R21: no peripheral pacing mem-to-mem
			if (cfg[DIR_LSB +: 2] == DIR_MEM2MEM) begin
				cfg[PACE_BIT] = 1'b0;
			end

			if (cfg[EN_BIT]) begin
				// R25: mem-to-mem forbids direct
				if (cfg[DIR_LSB +: 2] == DIR_MEM2MEM) begin
					mode[0] = 1'b1;
				end
				dmOff = mode[0];
				// R9 R10 R17: direct mode forcing
				if (!dmOff) begin
					cfg[MEM_BURST_LSB +: 2] = BURST_SINGLE;
					cfg[PER_BURST_LSB +: 2] = BURST_SINGLE;
					cfg[MEM_WIDTH_LSB +: 2] = cfg[PER_WIDTH_LSB +: 2];
				end
				// R14 R15: fixed step cleared
				if (!dmOff ||
					cfg[PER_BURST_LSB +: 2] != BURST_SINGLE) begin
					cfg[FIXED4_BIT] = 1'b0;
				end
				// R19: wraparound forcing
				if (cfg[DBUF_BIT]) begin
					cfg[WRAP_BIT] = 1'b1;
				end
				if (cfg[PACE_BIT]) begin
					cfg[WRAP_BIT] = 1'b0;
				end
			end

			s_d.cfg[i]  = cfg;
			s_d.mode[i] = mode;

			// Flag sets: a set in the clearing cycle wins.
			fb = flagBase(i);
			setBits[fb + FLAG_FIFO] = evtFifoErr[i];
			setBits[fb + FLAG_DME]  = evtDirectErr[i];
			setBits[fb + FLAG_ERR]  = evtError[i];
			setBits[fb + FLAG_HALF] = evtHalf[i];
			setBits[fb + FLAG_DONE] = evtComplete[i];
		end

		// R1 R2 R3 R4 R5: flag update
		s_d.flags = ((s_q.flags & ~clrBits) | setBits) & FLAG_MASK;

		for (int i = 0; i < NUM_STREAMS; i++) begin
			fb = flagBase(i);
			fl = s_d.flags[fb +: 6];
			cfg = s_d.cfg[i];
			// R22 R23 R26: enabled flags raise irq
			s_d.irq[i] = flagIrq(fl, cfg, s_d.mode[i][1]);
		end
	end

	// -------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_STREAMS; i++) begin
				s_q.cfg[i]  <= CFG_RESET;
				s_q.mode[i] <= MODE_RESET;
			end
			s_q.flags   <= 32'h0000_0000;
			s_q.prdata  <= 32'h0000_0000;
			s_q.pready  <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.irq     <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------
	assign prdata    = s_q.prdata;
	assign pready    = s_q.pready;
	assign pslverr   = s_q.pslverr;
	assign streamCfg = s_q.cfg;
	assign streamIrq = s_q.irq;

	always_comb begin
		for (int i = 0; i < NUM_STREAMS; i++) begin
			directModeOff[i] = s_q.mode[i][0];
		end
	end

endmodule // dsc_stream_ctrl

//--- verif/dsc_stream_ctrl_assertions.sv
// Port-level assertions for the upper-stream DMA configuration block.
`timescale 1ns/10ps
module dsc_stream_ctrl_assertions
	import dsc_pkg::*;
(
	// Clock, reset and APB
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic	pready,
	input wire logic [11:0]	paddr,
	// Engine side
	input wire logic [NUM_STREAMS-1:0]	xferEnd,
	input wire logic [NUM_STREAMS-1:0]	busFault,
	input wire logic [NUM_STREAMS-1:0][31:0]	streamCfg,
	input wire logic [NUM_STREAMS-1:0]	directModeOff
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic	wrDone;
	assign wrDone = psel && penable && pready && pwrite;
	for (genvar i = 0; i < NUM_STREAMS; i++) begin : g_st
		logic [31:0]	c;
		assign c = streamCfg[i];
		AST_DIRECT: assert property (
			c[EN_BIT] && !directModeOff[i] |-> c[24:21] == 4'h0 &&
			!c[FIXED4_BIT] && c[14:13] == c[12:11])
			else $error("direct mode fields not forced");
		AST_M2M_DMOFF: assert property (
			c[EN_BIT] && c[7:6] == DIR_MEM2MEM |-> directModeOff[i])
			else $error("direct mode kept for mem to mem");
		AST_M2M_FLOW: assert property (
			c[7:6] == DIR_MEM2MEM |-> !c[PACE_BIT])
			else $error("flow bit set for mem to mem");
		AST_WRAP_OFF: assert property (
			c[EN_BIT] && c[PACE_BIT] |-> !c[WRAP_BIT])
			else $error("wraparound kept with peripheral flow");
		AST_WRAP_ON: assert property (
			c[EN_BIT] && c[DBUF_BIT] && !c[PACE_BIT] |-> c[WRAP_BIT])
			else $error("wraparound not set for double buffer");
		AST_TARGET_FLIP: assert property (
			c[EN_BIT] && c[DBUF_BIT] && xferEnd[i] |=>
			c[TARGET_BIT] != $past(c[TARGET_BIT]))
			else $error("target did not switch");
		AST_STOP: assert property (
			c[EN_BIT] && busFault[i] && !wrDone |=> !c[EN_BIT])
			else $error("stream kept on after bus fault");
		AST_FROZEN: assert property (
			c[EN_BIT] && wrDone && paddr == 12'(CFG_BASE_OFS +
			STREAM_STRIDE * (FIRST_STREAM + i)) |=>
			$stable({c[27:25], c[18:16], c[7:6]}))
			else $error("protected field changed while on");
	end
endmodule // dsc_stream_ctrl_assertions

//--- verif/dsc_engine_model.sv
// Behavioural transfer engine that pulses stream events on command.
`timescale 1ns/10ps
module dsc_engine_model (
	// Clock
	input wire logic	clk,
	// Command from the bench
	input wire logic	go,
	input wire logic [2:0]	kind,
	input wire logic [3:0]	mask,
	// Events, transfer end, bus fault and threshold, one line each
	output logic [7:0][3:0]	pulse
);
	// Every pulse stands one cycle so the block counts it once.
	always_ff @(posedge clk) begin
		for (int k = 0; k < 8; k++)
			pulse[k] <= (go && kind == 3'(k)) ? mask : 4'h0;
	end
endmodule // dsc_engine_model

//--- verif/tb.sv
// Self-checking bench for the upper-stream DMA configuration block.
`timescale 1ns/10ps
module tb
	import dsc_pkg::*;
;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic	psel = 1'b0;
	logic	penable = 1'b0;
	logic	pwrite = 1'b0;
	logic	go = 1'b0;
	logic	pready, pslverr, er;
	logic [2:0]	kind = 3'h0;
	logic [3:0]	mask = 4'h0;
	logic [3:0]	dmOff, irq;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0000_0000;
	logic [31:0]	prdata, rd, x, m;
	logic [7:0][3:0]	pulse;
	logic [NUM_STREAMS-1:0][31:0]	cfg;
	int	error_cnt = 0;
	int	total_checks = 0;
	localparam logic [11:0] RA[5] = '{12'h070, 12'h088, 12'h00C,
		12'h010, 12'h0B8};
	localparam logic [31:0] RW[5] = '{32'hFFFF_FFFE, 32'h0000_00A0,
		32'hFFFF_FFFF, 32'h0000_0001, 32'h0145_4A5E};
	localparam logic [31:0] RE[5] = '{32'h0FEF_FFFE, 32'h0000_0080,
		32'h0000_0000, 32'h0000_0000, 32'h0145_4A5E};
	localparam logic RS[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam int FB[5] = '{5, 4, 3, 2, 0};

	initial forever #25 clk = ~clk;

	dsc_engine_model u_eng (.clk(clk), .go(go), .kind(kind),
		.mask(mask), .pulse(pulse));
	dsc_stream_ctrl uut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evtComplete(pulse[0]), .evtHalf(pulse[1]),
		.evtError(pulse[2]), .evtDirectErr(pulse[3]),
		.evtFifoErr(pulse[4]), .xferEnd(pulse[5]), .busFault(pulse[6]),
		.thresholdBad(pulse[7]), .streamCfg(cfg),
		.directModeOff(dmOff), .streamIrq(irq));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Holds the request until pready is sampled high, then releases.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			finish_test();
		end
		@(posedge clk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	task automatic ev(input logic [2:0] k, input logic [3:0] mk);
		go <= 1'b1;
		kind <= k;
		mask <= mk;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, RA[i], RW[i]);
			chk({31'h0, er}, {31'h0, RS[i]});
			rdc(RA[i], RE[i]);
		end
		for (int c = 0; c < 8; c++) begin
			x = 32'(c * 32'h0200_0000 + (c % 4) * 32'h00A1_0000
				+ (c % 3) * 32'h0000_2840);
			apb(1'b1, 12'h0A0, x);
			rdc(12'h0A0, x);
		end
		for (int k = 0; k < 5; k++)
			ev(3'(k), 4'hF);
		apb(1'b1, UPPER_CLEAR_OFS, 32'hF082_F082);
		x = 32'h0F7D_0F7D;
		rdc(UPPER_STATUS_OFS, x);
		chk({28'h0, irq}, 32'h0000_0009);
		foreach (FB[j]) begin
			m = 32'h0041_0041 << FB[j];
			x = x & ~m;
			apb(1'b1, UPPER_CLEAR_OFS, m);
			rdc(UPPER_STATUS_OFS, x);
		end
		chk({28'h0, irq}, 32'h0000_0000);
		apb(1'b1, 12'h070, 32'h01A4_9001);
		rdc(12'h070, 32'h0004_5101);
		apb(1'b1, 12'h070, 32'h0E00_0001);
		rdc(12'h070, 32'h0004_5101);
		ev(3'h5, 4'h1);
		chk(cfg[0], 32'h000C_5101);
		ev(3'h6, 4'h1);
		chk(cfg[0], 32'h000C_5100);
		apb(1'b1, 12'h088, 32'h0000_00A1);
		chk({31'h0, dmOff[1]}, 32'h0000_0001);
		ev(3'h7, 4'h2);
		chk(cfg[1], 32'h0000_0080);
		apb(1'b1, 12'h0B4, 32'h0000_0004);
		apb(1'b1, 12'h0A0, 32'h0004_0121);
		chk(cfg[2], 32'h0004_0021);
		apb(1'b1, 12'h0CC, 32'h0000_0080);
		ev(3'h4, 4'h8);
		chk({28'h0, irq}, 32'h0000_0008);
		apb(1'b1, UPPER_CLEAR_OFS, 32'h0040_0000);
		chk({28'h0, irq}, 32'h0000_0000);
		rst_n <= 1'b0;
		@(posedge clk);
		chk(cfg[0], 32'h0000_0000);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(12'h0B8, 32'h0000_0000);
		finish_test();
	end
endmodule // tb

bind dsc_stream_ctrl dsc_stream_ctrl_assertions u_chk (.clk(clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .paddr(paddr), .xferEnd(xferEnd),
	.busFault(busFault), .streamCfg(streamCfg),
	.directModeOff(directModeOff));
